// *** design/mbsu_pkg.sv ***
// Package of constants and types for the memory barrier sync unit.
// Assumes a single core clock domain.
package mbsu_pkg;
	// ****************************************
	// Barrier kinds
	// ****************************************
	typedef enum logic [2:0] {
		MBSU_OP_NONE,
		MBSU_OP_ORDER,
		MBSU_OP_COMPLETE,
		MBSU_OP_FLUSH,
		MBSU_OP_DPRELOAD,
		MBSU_OP_IPRELOAD
	} mbsu_op_type;

	// ****************************************
	// Controller states
	// ****************************************
	typedef enum logic [2:0] {
		MBSU_IDLE,
		MBSU_ORDER_DRAIN,
		MBSU_COMPLETE_DRAIN,
		MBSU_FLUSH_DRAIN,
		MBSU_REFETCH
	} mbsu_state_type;

	// ****************************************
	// Sizes and reset values
	// ****************************************
	localparam int MBSU_CNT_W = 6;
	localparam logic [MBSU_CNT_W-1:0] MBSU_CNT_RST = 6'h00;
	localparam int MBSU_LINES = 16;
	localparam int MBSU_IDX_W = 4;
	localparam int MBSU_TAG_W = 24;
	localparam int MBSU_OFS_W = 4;
	localparam int MBSU_ADDR_W = 32;
	localparam int MBSU_DATA_W = 32;
	localparam logic [3:0] MBSU_FLUSH_CYCLES = 4'h2;
endpackage

// *** design/mbsu_outstanding.sv ***
// Counter of outstanding explicit accesses and context-altering control accesses.
// Assumes issue and done pulses on the core clock, done never exceeds issue.
`timescale 1ns/100ps
`default_nettype none
module mbsu_outstanding
	import mbsu_pkg::*;
(
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic issue,
	input wire logic done,
	output logic empty
);
	// ****************************************
	// Counter
	// ****************************************
	logic [MBSU_CNT_W-1:0] count;
	logic [MBSU_CNT_W-1:0] next_count;

	always_comb begin
		next_count = count;
		if (issue && !done) begin
			next_count = count + 6'h01;
		end else if (!issue && done && count != MBSU_CNT_RST) begin
			next_count = count - 6'h01;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			count <= MBSU_CNT_RST;
		end else begin
			count <= next_count;
		end
	end

	assign empty = (count == MBSU_CNT_RST) && !issue;
endmodule
`default_nettype wire

// *** design/mbsu_cache.sv ***
// Small direct-mapped read cache with line fill from memory.
// Assumes memory answers a fill with a single mem_valid pulse carrying the word.
`timescale 1ns/100ps
`default_nettype none
module mbsu_cache
	import mbsu_pkg::*;
(
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic req,
	input wire logic [MBSU_ADDR_W-1:0] addr,
	input wire logic mem_valid,
	input wire logic [MBSU_DATA_W-1:0] mem_data,
	output logic hit,
	output logic filling,
	output logic [MBSU_DATA_W-1:0] rdata
);
	// ****************************************
	// Storage
	// ****************************************
	logic [MBSU_DATA_W-1:0] line_mem [MBSU_LINES];
	logic [MBSU_TAG_W-1:0] tag_mem [MBSU_LINES];
	logic [MBSU_LINES-1:0] valid;
	logic [MBSU_LINES-1:0] next_valid;
	logic [MBSU_IDX_W-1:0] idx;
	logic [MBSU_TAG_W-1:0] tag;
	logic busy;
	logic next_busy;
	logic [MBSU_IDX_W-1:0] fill_idx;
	logic [MBSU_IDX_W-1:0] next_fill_idx;
	logic [MBSU_TAG_W-1:0] fill_tag;
	logic [MBSU_TAG_W-1:0] next_fill_tag;

	assign idx = addr[MBSU_OFS_W+MBSU_IDX_W-1:MBSU_OFS_W];
	assign tag = addr[MBSU_ADDR_W-1:MBSU_ADDR_W-MBSU_TAG_W];
	// Hit served in the same cycle, miss allocates
	assign hit = req && valid[idx] && tag_mem[idx] == tag && !busy;
	assign filling = busy;
	assign rdata = line_mem[idx];

	always_comb begin
		next_valid = valid;
		next_busy = busy;
		next_fill_idx = fill_idx;
		next_fill_tag = fill_tag;
		if (!busy && req && !hit) begin
			next_busy = 1'b1;
			next_fill_idx = idx;
			next_fill_tag = tag;
			next_valid[idx] = 1'b0;
		end else if (busy && mem_valid) begin
			next_busy = 1'b0;
			next_valid[fill_idx] = 1'b1;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			valid <= '0;
			busy <= 1'b0;
			fill_idx <= '0;
			fill_tag <= '0;
		end else begin
			valid <= next_valid;
			busy <= next_busy;
			fill_idx <= next_fill_idx;
			fill_tag <= next_fill_tag;
		end
	end

	// One word per line keeps the fill a single beat
	always_ff @(posedge clk_sys) begin
		if (busy && mem_valid) begin
			line_mem[fill_idx] <= mem_data;
			tag_mem[fill_idx] <= fill_tag;
		end
	end
endmodule
`default_nettype wire

// *** design/mbsu_top.sv ***
// Barrier and synchronisation control between pipeline and memory system.
// Assumes pipeline issues one barrier op at a time and honours the stall.
`timescale 1ns/100ps
`default_nettype none
module mbsu_top
	import mbsu_pkg::*;
#(
	parameter int PREFETCH_DEPTH = 4,
	parameter logic [3:0] FLUSH_CYCLES = MBSU_FLUSH_CYCLES
)
(
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic op_valid,
	input wire mbsu_op_type op_kind,
	input wire logic mem_issue,
	input wire logic mem_done,
	input wire logic ctl_issue,
	input wire logic ctl_done,
	input wire logic ctx_req,
	input wire logic exc_event,
	input wire logic hint_bus_error,
	input wire logic cache_req,
	input wire logic [MBSU_ADDR_W-1:0] cache_addr,
	input wire logic fill_valid,
	input wire logic [MBSU_DATA_W-1:0] fill_data,
	input wire logic branch_taken_pred,
	output logic mem_hold,
	output logic pipe_stall,
	output logic pipe_flush,
	output logic refetch,
	output logic bp_ctx_update,
	output logic ctx_apply,
	output logic imprecise_fault,
	output logic op_done,
	output logic cache_hit,
	output logic cache_fill,
	output logic [MBSU_DATA_W-1:0] cache_rdata,
	output logic pf_follow_target,
	output logic [3:0] pf_depth
);
	// ****************************************
	// Outstanding trackers
	// ****************************************
	logic mem_empty;
	logic ctl_empty;
	logic all_empty;
	logic c_hit;
	logic c_fill;
	logic [MBSU_DATA_W-1:0] c_rdata;

	mbsu_outstanding u_mem_cnt (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.issue(mem_issue),
		.done(mem_done),
		.empty(mem_empty)
	);

	// Control-space accesses are counted apart so each one retires before its effect
	mbsu_outstanding u_ctl_cnt (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.issue(ctl_issue),
		.done(ctl_done),
		.empty(ctl_empty)
	);

	// Release depends on the memory system's own completion report
	assign all_empty = mem_empty && ctl_empty;

	mbsu_cache u_cache (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.req(cache_req),
		.addr(cache_addr),
		.mem_valid(fill_valid),
		.mem_data(fill_data),
		.hit(c_hit),
		.filling(c_fill),
		.rdata(c_rdata)
	);

	// ****************************************
	// Barrier controller
	// ****************************************
	mbsu_state_type state;
	mbsu_state_type next_state;
	logic [3:0] flush_cnt;
	logic [3:0] next_flush_cnt;
	logic next_mem_hold;
	logic next_pipe_stall;
	logic next_pipe_flush;
	logic next_refetch;
	logic next_bp_ctx_update;
	logic next_ctx_apply;
	logic next_fault;
	logic next_op_done;
	logic ctx_pending;
	logic next_ctx_pending;

	always_comb begin
		next_state = state;
		next_flush_cnt = flush_cnt;
		next_mem_hold = 1'b0;
		next_pipe_stall = 1'b0;
		next_pipe_flush = 1'b0;
		next_refetch = 1'b0;
		next_bp_ctx_update = 1'b0;
		next_ctx_apply = 1'b0;
		next_op_done = 1'b0;
		next_ctx_pending = ctx_pending || ctx_req;
		// Preload faults never surface as precise exceptions
		next_fault = hint_bus_error;
		unique case (state)
			MBSU_IDLE: begin
				// Control accesses complete before context changes apply
				if (next_ctx_pending && ctl_empty) begin
					next_ctx_apply = 1'b1;
					next_ctx_pending = 1'b0;
				end
				if (op_valid) begin
					unique case (op_kind)
						MBSU_OP_ORDER: begin
							// Only later memory issue waits, the pipeline keeps going
							next_mem_hold = !mem_empty;
							next_state = mem_empty ? MBSU_IDLE : MBSU_ORDER_DRAIN;
							next_op_done = mem_empty;
						end
						MBSU_OP_COMPLETE: begin
							next_mem_hold = 1'b1;
							next_pipe_stall = 1'b1;
							next_state = MBSU_COMPLETE_DRAIN;
						end
						MBSU_OP_FLUSH: begin
							next_pipe_stall = 1'b1;
							next_pipe_flush = 1'b1;
							next_flush_cnt = FLUSH_CYCLES;
							next_state = MBSU_FLUSH_DRAIN;
						end
						MBSU_OP_DPRELOAD, MBSU_OP_IPRELOAD: begin
							next_op_done = 1'b1;
						end
						default: begin
							next_state = MBSU_IDLE;
						end
					endcase
				end else if (exc_event) begin
					next_pipe_flush = 1'b1;
					next_refetch = 1'b1;
				end
			end
			MBSU_ORDER_DRAIN: begin
				next_mem_hold = !mem_empty;
				if (mem_empty) begin
					next_op_done = 1'b1;
					next_state = MBSU_IDLE;
				end
			end
			MBSU_COMPLETE_DRAIN: begin
				// Waits on both explicit and context-altering control traffic
				next_mem_hold = !all_empty;
				next_pipe_stall = !all_empty;
				if (all_empty) begin
					next_op_done = 1'b1;
					next_state = MBSU_IDLE;
				end
			end
			MBSU_FLUSH_DRAIN: begin
				// Context changes after the flush stay parked until it executes
				next_pipe_stall = 1'b1;
				if (flush_cnt != 4'h0) begin
					next_flush_cnt = flush_cnt - 4'h1;
				end else begin
					next_state = MBSU_REFETCH;
				end
			end
			MBSU_REFETCH: begin
				next_refetch = 1'b1;
				next_bp_ctx_update = 1'b1;
				next_op_done = 1'b1;
				next_state = MBSU_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			state <= MBSU_IDLE;
			flush_cnt <= 4'h0;
			mem_hold <= 1'b0;
			pipe_stall <= 1'b0;
			pipe_flush <= 1'b0;
			refetch <= 1'b0;
			bp_ctx_update <= 1'b0;
			ctx_apply <= 1'b0;
			imprecise_fault <= 1'b0;
			op_done <= 1'b0;
			ctx_pending <= 1'b0;
		end else begin
			state <= next_state;
			flush_cnt <= next_flush_cnt;
			mem_hold <= next_mem_hold;
			pipe_stall <= next_pipe_stall;
			pipe_flush <= next_pipe_flush;
			refetch <= next_refetch;
			bp_ctx_update <= next_bp_ctx_update;
			ctx_apply <= next_ctx_apply;
			imprecise_fault <= next_fault;
			op_done <= next_op_done;
			ctx_pending <= next_ctx_pending;
		end
	end

	// ****************************************
	// Prefetch and cache outputs
	// ****************************************
	// Unordered traffic is never held: mem_hold only reflects a live barrier
	logic next_pf_target;
	logic [3:0] next_pf_depth;
	logic [MBSU_DATA_W-1:0] next_rdata;

	always_comb begin
		next_pf_target = branch_taken_pred;
		// Depth shrinks to zero while any barrier is in flight (next state not idle), full otherwise
		next_pf_depth = (next_state == MBSU_IDLE) ? 4'(PREFETCH_DEPTH) : 4'h0;
		next_rdata = c_rdata;
	end

	// Already-fetched words are not invalidated by stores; only a flush or an exception refetches
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			pf_follow_target <= 1'b0;
			pf_depth <= 4'h0;
			cache_hit <= 1'b0;
			cache_fill <= 1'b0;
			cache_rdata <= '0;
		end else begin
			pf_follow_target <= next_pf_target;
			pf_depth <= next_pf_depth;
			cache_hit <= c_hit;
			cache_fill <= c_fill;
			cache_rdata <= next_rdata;
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	AST_ORDER_NO_STALL: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(state == MBSU_ORDER_DRAIN) |=> !pipe_stall)
		else $error("ordering barrier stalled pipeline");
	AST_COMPLETE_STALL: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(state == MBSU_IDLE && op_valid && op_kind == MBSU_OP_COMPLETE) |=> pipe_stall && mem_hold)
		else $error("completion barrier did not stall");
	AST_COMPLETE_WAIT: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(state == MBSU_COMPLETE_DRAIN && !all_empty) |=> !op_done)
		else $error("completion finished with accesses outstanding");
	AST_COMPLETE_END: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(state == MBSU_COMPLETE_DRAIN && all_empty) |=> op_done && state == MBSU_IDLE)
		else $error("completion did not end when drained");
	AST_FLUSH_SEQ: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(state == MBSU_IDLE && op_valid && op_kind == MBSU_OP_FLUSH)
		|=> (pipe_flush && pipe_stall) ##1 pipe_stall [*2]
		##1 (pipe_stall && state == MBSU_REFETCH) ##1 (refetch && !pipe_stall))
		else $error("flush sequence wrong");
	AST_BP_UPDATE: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(state == MBSU_REFETCH) |=> refetch && bp_ctx_update && op_done)
		else $error("refetch or predictor update missing");
	AST_CTX_HELD: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(state == MBSU_FLUSH_DRAIN) |=> !ctx_apply)
		else $error("context applied during flush");
	AST_EXC_REFETCH: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(state == MBSU_IDLE && !op_valid && exc_event) |=> pipe_flush && refetch)
		else $error("exception did not refetch");
	AST_HINT_NOP: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(state == MBSU_IDLE && op_valid && op_kind == MBSU_OP_DPRELOAD)
		|=> op_done && !pipe_stall && !pipe_flush)
		else $error("preload hint not a no-op");
	AST_HINT_FAULT: assert property (@(posedge clk_sys) disable iff (sys_rst)
		hint_bus_error |=> imprecise_fault)
		else $error("preload fault not reported");
endmodule
`default_nettype wire

// *** tb/mbsu_mem_model.sv ***
// Memory system model: completes accesses and fills cache lines.
// Assumes issue pulses and fill requests sampled on clk_sys.
`timescale 1ns/100ps
`default_nettype none
module mbsu_mem_model
	import mbsu_pkg::*;
#(
	parameter int DLY = 3
)
(
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic mem_issue,
	input wire logic ctl_issue,
	input wire logic cache_fill,
	input wire logic [MBSU_ADDR_W-1:0] cache_addr,
	output logic mem_done,
	output logic ctl_done,
	output logic fill_valid,
	output logic [MBSU_DATA_W-1:0] fill_data
);
	int cyc = 0;
	int mq[$];
	int cq[$];
	initial begin
		mem_done = 0;
		ctl_done = 0;
		fill_valid = 0;
		fill_data = 32'h0;
	end
	// ****************************************
	// Completion and line fill
	// ****************************************
	always @(posedge clk_sys) begin
		cyc = cyc + 1;
		if (sys_rst) begin
			mq.delete();
			cq.delete();
		end
		if (mem_issue) mq.push_back(cyc + DLY);
		// Control writes are slower, so they outlast plain accesses
		if (ctl_issue) cq.push_back(cyc + DLY + 2);
		mem_done <= mq.size() > 0 && mq[0] == cyc + 1;
		ctl_done <= cq.size() > 0 && cq[0] == cyc + 1;
		if (mq.size() > 0 && mq[0] == cyc + 1)
			void'(mq.pop_front());
		if (cq.size() > 0 && cq[0] == cyc + 1)
			void'(cq.pop_front());
		fill_valid <= cache_fill && !fill_valid && !sys_rst;
		// Released data line toggles so stale data never looks valid
		fill_data <= (cache_fill && !fill_valid) ? cache_addr ^ 32'h5a5a_5a5a : ~fill_data;
	end
endmodule
`default_nettype wire

// *** tb/test_mbsu_top.sv ***
// Bench for the barrier sync unit: ops, exceptions, hints, cache, prefetch.
// Assumes the memory model answers plain accesses after DLY cycles and control accesses after DLY + 2.
`timescale 1ns/100ps
`default_nettype none
module test_mbsu_top
	import mbsu_pkg::*;
;
	localparam int DLY = 3;
	localparam int PF = 3;
	typedef struct {int lat; logic stall; logic hold; logic rf;} mbsu_note_type;
	logic clk_sys, sys_rst, op_valid, mem_issue, mem_done, ctl_issue, ctl_done;
	logic ctx_req, exc_event, hint_bus_error, cache_req, fill_valid, branch_taken_pred;
	logic mem_hold, pipe_stall, pipe_flush, refetch, bp_ctx_update, ctx_apply;
	logic imprecise_fault, op_done, cache_hit, cache_fill, pf_follow_target, g, b;
	logic [MBSU_ADDR_W-1:0] cache_addr;
	logic [MBSU_DATA_W-1:0] fill_data, cache_rdata;
	logic [3:0] pf_depth;
	mbsu_op_type op_kind;
	mbsu_note_type nq[$];
	mbsu_note_type n;
	int cyc = 0, t0 = 0, bad_count = 0, n_checks = 0, i;
	logic st_seen = 0, hd_seen = 0, fl_seen = 0;
	mbsu_top #(.PREFETCH_DEPTH(PF)) dut (.clk_sys(clk_sys), .sys_rst(sys_rst),
		.op_valid(op_valid), .op_kind(op_kind), .mem_issue(mem_issue), .mem_done(mem_done),
		.ctl_issue(ctl_issue), .ctl_done(ctl_done), .ctx_req(ctx_req), .exc_event(exc_event),
		.hint_bus_error(hint_bus_error), .cache_req(cache_req), .cache_addr(cache_addr),
		.fill_valid(fill_valid), .fill_data(fill_data), .branch_taken_pred(branch_taken_pred),
		.mem_hold(mem_hold), .pipe_stall(pipe_stall), .pipe_flush(pipe_flush),
		.refetch(refetch), .bp_ctx_update(bp_ctx_update), .ctx_apply(ctx_apply),
		.imprecise_fault(imprecise_fault), .op_done(op_done), .cache_hit(cache_hit),
		.cache_fill(cache_fill), .cache_rdata(cache_rdata),
		.pf_follow_target(pf_follow_target), .pf_depth(pf_depth));
	mbsu_mem_model #(.DLY(DLY)) mem (.clk_sys(clk_sys), .sys_rst(sys_rst),
		.mem_issue(mem_issue), .ctl_issue(ctl_issue), .cache_fill(cache_fill),
		.cache_addr(cache_addr), .mem_done(mem_done), .ctl_done(ctl_done),
		.fill_valid(fill_valid), .fill_data(fill_data));
	// ****************************************
	// Clock, checking and closing
	// ****************************************
	always #2 clk_sys = ~clk_sys;
	always @(posedge clk_sys) cyc <= cyc + 1;
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] %s exp %h got %h", what, exp, got);
		end
	endtask
	task automatic tally_and_finish();
		if (bad_count == 0 && n_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic tick();
		@(posedge clk_sys);
		#1;
	endtask
	// Watches for one output pulse over lim cycles
	task automatic seen(input int which, input int lim, output logic got);
		got = 0;
		for (int k = 0; k < lim; k++) begin
			@(negedge clk_sys);
			got |= (which == 0) ? refetch : (which == 1) ? imprecise_fault : ctx_apply;
		end
	endtask
	// ****************************************
	// Result monitor
	// ****************************************
	always @(negedge clk_sys) begin
		st_seen |= pipe_stall;
		hd_seen |= mem_hold;
		fl_seen |= pipe_flush;
		if (op_done === 1'b1 && nq.size() == 0)
			check("stray op_done", 0, 1);
		else if (op_done === 1'b1) begin
			n = nq.pop_front();
			check("latency", n.lat, cyc - t0);
			check("stall", n.stall, st_seen);
			if (n.hold !== 1'bx)
				check("hold", n.hold, hd_seen);
			check("refetch", n.rf, refetch);
			check("flush", n.rf, fl_seen);
			check("bp_ctx", n.rf, bp_ctx_update);
		end
	end
	// ****************************************
	// Stimulus
	// ****************************************
	// Busy flag presents a second op mid-flight, which must be ignored
	task automatic op(input mbsu_op_type k, input logic mi, input logic ci, input int lat,
			input logic s, input logic h, input logic busy);
		nq.push_back('{lat, s, h, k == MBSU_OP_FLUSH});
		st_seen = 0;
		hd_seen = 0;
		fl_seen = 0;
		t0 = cyc;
		op_valid = 1;
		op_kind = k;
		mem_issue = mi;
		ctl_issue = ci;
		tick();
		op_valid = busy;
		op_kind = MBSU_OP_ORDER;
		mem_issue = 0;
		ctl_issue = 0;
		tick();
		op_valid = 0;
		for (int k2 = 0; k2 < 40 && nq.size() != 0; k2++)
			tick();
		check("op pending", 0, nq.size());
		nq.delete();
	endtask
	initial begin
		{clk_sys, op_valid, mem_issue, ctl_issue, ctx_req, exc_event} = 0;
		{hint_bus_error, cache_req, branch_taken_pred} = 0;
		op_kind = MBSU_OP_NONE;
		cache_addr = 32'h0;
		sys_rst = 1;
		void'($urandom(70733));
		repeat (5) tick();
		sys_rst = 0;
		check("rst depth", 0, pf_depth);
		tick();
		check("depth", PF, pf_depth);
		op(MBSU_OP_ORDER, 0, 0, 1, 0, 0, 0);
		op(MBSU_OP_ORDER, 1, 0, DLY + 2, 0, 1, 0);
		op(MBSU_OP_COMPLETE, 0, 0, 2, 1, 1, 0);
		op(MBSU_OP_COMPLETE, 1, 0, DLY + 2, 1, 1, 0);
		op(MBSU_OP_COMPLETE, 0, 1, DLY + 4, 1, 1, 0);
		op(MBSU_OP_FLUSH, 0, 0, 5, 1, 0, 1);
		op(MBSU_OP_DPRELOAD, 0, 0, 1, 0, 0, 0);
		op(MBSU_OP_IPRELOAD, 0, 0, 1, 0, 0, 0);
		exc_event = 1;
		tick();
		exc_event = 0;
		seen(0, 6, g);
		check("exc refetch", 1, g);
		tick();
		hint_bus_error = 1;
		tick();
		hint_bus_error = 0;
		seen(1, 6, g);
		check("imprecise", 1, g);
		tick();
		ctl_issue = 1;
		ctx_req = 1;
		tick();
		{ctl_issue, ctx_req} = 0;
		seen(2, DLY + 1, g);
		check("early ctx", 0, g);
		seen(2, 6, g);
		check("ctx apply", 1, g);
		for (i = 0; i < 3; i++) begin
			tick();
			cache_addr = $urandom();
			cache_req = 1;
			tick();
			cache_req = 0;
			@(negedge clk_sys);
			check("miss hit", 0, cache_hit);
			@(negedge clk_sys);
			check("miss fill", 1, cache_fill);
			for (int k = 0; k < 10 && cache_fill !== 1'b0; k++)
				@(negedge clk_sys);
			tick();
			cache_req = 1;
			tick();
			cache_req = 0;
			@(negedge clk_sys);
			check("hit", 1, cache_hit);
			check("rdata", cache_addr ^ 32'h5a5a_5a5a, cache_rdata);
		end
		for (i = 0; i < 8; i++) begin
			tick();
			b = $urandom();
			branch_taken_pred = b;
			tick();
			check("pf path", b, pf_follow_target);
		end
		tally_and_finish();
	end
	initial begin
		#(4 * 20000);
		bad_count++;
		tally_and_finish();
	end
endmodule
`default_nettype wire
